/* File: bench/uvm_monitor_properties.sv */
// port assertions of the undervoltage monitor
`timescale 1ns/10ps
`default_nettype none
module uvm_monitor_properties (
  input wire logic clk_sys_i,      // cpu clock
  input wire logic rst_n_i,        // async reset
  input wire logic below_fall_i,   // low report
  input wire logic above_rise_i,   // high report
  input wire logic psel_i,         // apb select
  input wire logic penable_i,      // apb enable
  input wire logic pready_o,       // apb ready
  input wire logic pslverr_o,      // apb error
  input wire logic sys_reset_o,    // reset request
  input wire logic ext_reset_n_o,  // reset pin
  input wire logic wake_o,         // wake pulse
  input wire logic comparator_on_o // monitor power
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  logic [3:0] low_cnt_r;
  // raw low run length; sync delay is allowed for below
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) low_cnt_r <= 4'h0;
    else if (!below_fall_i) low_cnt_r <= 4'h0;
    else if (low_cnt_r != 4'hF) low_cnt_r <= low_cnt_r + 4'h1;
  end
  a_pin_follows: assert property (ext_reset_n_o == !sys_reset_o)
    else $error("reset pin differs");
  a_nine_low: assert property ($rose(sys_reset_o) |->
    $past(low_cnt_r, 2) >= 4'h9) else $error("early reset");
  a_fast_release: assert property (sys_reset_o && above_rise_i |-> ##[1:5] !sys_reset_o)
    else $error("reset not released");
  a_held_reset: assert property ($fell(sys_reset_o) |-> $past(above_rise_i, 2) ||
    $past(above_rise_i, 3) || $past(above_rise_i, 4)) else $error("release without rise");
  a_power_needed: assert property ($rose(sys_reset_o) |-> comparator_on_o)
    else $error("reset while off");
  a_one_wait: assert property (psel_i && penable_i && !pready_o |=> pready_o)
    else $error("no ready");
  a_ready_access: assert property (pready_o |-> psel_i && penable_i)
    else $error("stray ready");
  a_err_ready: assert property (pslverr_o |-> pready_o)
    else $error("error without ready");
  a_wake_pulse: assert property (wake_o |=> !wake_o)
    else $error("wake too long");
  a_wake_reset: assert property (wake_o |-> ##[0:1] sys_reset_o)
    else $error("wake without reset");
  c_reset: cover property ($rose(sys_reset_o));
  c_wake: cover property (wake_o);
  c_error: cover property (pslverr_o);
endmodule : uvm_monitor_properties
`default_nettype wire

/* File: bench/uvm_monitor_tb_top.sv */
// bench for the undervoltage monitor
`timescale 1ns/10ps
`default_nettype none
module uvm_monitor_tb_top;
  localparam logic [11:0] ST = uvm_pkg::UVM_OFS_STATUS;
  localparam logic [11:0] CF = uvm_pkg::UVM_OFS_CONFIG;
  localparam logic [11:0] EV = uvm_pkg::UVM_OFS_IRQ_ST;
  logic clk_sys_i = 1'b0, rst_n_i = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic wmode = 1'b0, woke = 1'b0, err, pready, pslverr, srst, ext_n, wake, con, irq, bf, ar, rc;
  logic [1:0] level = 2'h2;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  int failures = 0, n_checks = 0;
  uvm_supply_model i_sup (.clk_sys_i, .level_i(level), .below_fall_o(bf), .above_rise_o(ar),
    .ref_clk_o(rc));
  uvm_monitor i_dut (.clk_sys_i, .rst_n_i, .below_fall_i(bf), .above_rise_i(ar), .ref_clk_i(rc),
    .wait_mode_i(wmode), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .sys_reset_o(srst), .ext_reset_n_o(ext_n), .wake_o(wake), .comparator_on_o(con), .irq_o(irq));
  always #2 clk_sys_i = ~clk_sys_i;
  // wake is a pulse, so keep a sticky copy
  always @(posedge clk_sys_i) if (wake === 1'b1) woke <= 1'b1;
  ////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic stop_test();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test
  // apb transfer; ready and data are taken as they stood at the rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys_i);
    penable <= 1'b1;
    do @(posedge clk_sys_i); while (pready !== 1'b1 && ++n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // settle so outputs launched at the completing edge are visible
    @(negedge clk_sys_i);
    if (n >= 50) begin
      failures++;
      stop_test();
    end
  endtask : apb
  // supply level held for n sampled cycles
  task automatic lvl(input logic [1:0] v, input int n);
    @(posedge clk_sys_i);
    level <= v;
    repeat (n) @(negedge clk_sys_i);
  endtask : lvl
  initial begin
    repeat (10) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    apb(1'b0, ST, 32'h0);
    chk("status", 32'h0, rd);
    chk("monitor on", 32'h1, 32'(con));
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped", 32'h1, 32'(err));
    lvl(2'h0, 8);
    lvl(2'h1, 1);
    lvl(2'h0, 8);
    lvl(2'h1, 8);
    chk("short dips", 32'h0, 32'(srst));
    lvl(2'h0, 9);
    lvl(2'h1, 8);
    chk("reset", 32'h1, 32'(srst));
    chk("pin", 32'h0, 32'(ext_n));
    chk("no wake", 32'h0, 32'(woke));
    apb(1'b0, EV, 32'h0);
    chk("event", 32'h1, rd);
    chk("irq masked", 32'h0, 32'(irq));
    apb(1'b1, uvm_pkg::UVM_OFS_IRQ_MK, 32'h1);
    chk("irq", 32'h1, 32'(irq));
    apb(1'b1, EV, 32'h1);
    chk("irq cleared", 32'h0, 32'(irq));
    lvl(2'h2, 1);
    lvl(2'h1, 8);
    chk("released", 32'h0, 32'(srst));
    apb(1'b1, CF, 32'h2);
    lvl(2'h0, 50);
    apb(1'b0, ST, 32'h0);
    chk("flag early", 32'h0, rd);
    lvl(2'h0, 40);
    apb(1'b0, ST, 32'h0);
    chk("flag", 32'h80, rd);
    chk("polled", 32'h0, 32'(srst));
    chk("irq bit1 masked", 32'h0, 32'(irq));
    lvl(2'h1, 10);
    apb(1'b1, ST, 32'h0);
    apb(1'b0, ST, 32'h0);
    chk("flag held", 32'h80, rd);
    lvl(2'h2, 1);
    lvl(2'h1, 10);
    apb(1'b0, ST, 32'h0);
    chk("flag clear", 32'h0, rd);
    apb(1'b1, CF, 32'h0);
    @(posedge clk_sys_i);
    wmode <= 1'b1;
    lvl(2'h0, 12);
    lvl(2'h1, 4);
    chk("wait reset", 32'h1, 32'(srst));
    chk("wake", 32'h1, 32'(woke));
    lvl(2'h2, 1);
    @(posedge clk_sys_i);
    wmode <= 1'b0;
    apb(1'b1, CF, 32'h1);
    lvl(2'h0, 20);
    chk("off reset", 32'h0, 32'(srst));
    chk("off", 32'h0, 32'(con));
    apb(1'b1, CF, 32'h2);
    lvl(2'h0, 100);
    apb(1'b0, ST, 32'h0);
    chk("flag before reset", 32'h80, rd);
    rst_n_i <= 1'b0;
    @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    lvl(2'h1, 4);
    apb(1'b0, ST, 32'h0);
    chk("flag reset", 32'h0, rd);
    apb(1'b0, CF, 32'h0);
    chk("config reset", 32'h0, rd);
    stop_test();
  end
  initial begin
    #40000;
    failures++;
    stop_test();
  end
endmodule : uvm_monitor_tb_top
bind uvm_monitor uvm_monitor_properties i_props (.clk_sys_i, .rst_n_i, .below_fall_i,
  .above_rise_i, .psel_i, .penable_i, .pready_o, .pslverr_o, .sys_reset_o, .ext_reset_n_o,
  .wake_o, .comparator_on_o);
`default_nettype wire

/* File: bench/uvm_supply_model.sv */
// supply comparator and oscillator model
`timescale 1ns/10ps
`default_nettype none
module uvm_supply_model (
  input  wire logic       clk_sys_i,    // bench clock
  input  wire logic [1:0] level_i,      // 0 low, 1 mid, 2 high
  output var  logic       below_fall_o, // low report
  output var  logic       above_rise_o, // high report
  output var  logic       ref_clk_o     // reference clock
);
  // oscillator runs free at half the cpu rate
  initial ref_clk_o = 1'b0;
  always @(posedge clk_sys_i) ref_clk_o <= ~ref_clk_o;
  // mid band reports neither level
  assign below_fall_o = (level_i == 2'h0);
  assign above_rise_o = (level_i == 2'h2);
endmodule : uvm_supply_model
`default_nettype wire

/* File: rtl/uvm_monitor.sv */
// undervoltage monitor: filters, reset generation and apb registers
`timescale 1ns/10ps
`default_nettype none
module uvm_monitor #(
  parameter int RST_FILTER  = uvm_pkg::UVM_RST_FILTER_CYC,  // cpu cycles
  parameter int FLAG_FILTER = uvm_pkg::UVM_FLAG_FILTER_CYC  // reference cycles
) (
  input  wire logic        clk_sys_i,        // cpu clock
  input  wire logic        rst_n_i,          // async reset, active low
  input  wire logic        below_fall_i,     // comparator: at/below falling trip
  input  wire logic        above_rise_i,     // comparator: above rising trip
  input  wire logic        ref_clk_i,        // oscillator reference clock pin
  input  wire logic        wait_mode_i,      // cpu in low-power wait
  input  wire logic        psel_i,           // apb select
  input  wire logic        penable_i,        // apb enable
  input  wire logic        pwrite_i,         // apb direction
  input  wire logic [11:0] paddr_i,          // apb address
  input  wire logic [31:0] pwdata_i,         // apb write data
  output logic      [31:0] prdata_o,         // apb read data
  output logic             pready_o,         // apb ready
  output logic             pslverr_o,        // apb error
  output logic             sys_reset_o,      // system reset request
  output logic             ext_reset_n_o,    // external reset pin, low active
  output logic             wake_o,           // wake from wait pulse
  output logic             comparator_on_o,  // analog comparator power
  output logic             irq_o             // summary event interrupt
);

  ////////////////////////////////////////////////////////////////////////////
  // elaboration checks
  initial begin
    if (RST_FILTER < 1 || RST_FILTER > 255) begin
      $error("reset filter out of range");
    end
    if (FLAG_FILTER < uvm_pkg::UVM_FLAG_MIN_CYC || FLAG_FILTER > uvm_pkg::UVM_FLAG_MAX_CYC) begin
      $error("flag filter outside permitted window");
    end
  end

  localparam logic [7:0] RST_LAST  = 8'(RST_FILTER - 1);
  localparam logic [7:0] FLAG_LAST = 8'(FLAG_FILTER - 1);

  ////////////////////////////////////////////////////////////////////////////
  // synchronised pins
  logic [2:0]        pins_s;
  uvm_pkg::uvm_cmp_t cmp;

  uvm_sync #(
    .WIDTH (3)
  ) u_sync (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .async_i   ({ref_clk_i, above_rise_i, below_fall_i}),
    .sync_o    (pins_s)
  );

  assign cmp.below_fall = pins_s[0];
  assign cmp.above_rise = pins_s[1];

  ////////////////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    uvm_pkg::uvm_state_t st;
    logic [7:0]          rst_cnt;
    logic [7:0]          flag_cnt;
    logic                ref_d;
    logic                flag;
    logic                pwr_low;
    logic                rst_low;
    logic [1:0]          ev;
    logic [1:0]          mask;
    logic [31:0]         rdata;
    logic                ready;
    logic                err;
    logic                sys_rst;
    logic                ext_n;
    logic                wake;
    logic                cmp_on;
    logic                irq;
  } uvm_regs_t;

  uvm_regs_t q_r;
  uvm_regs_t q_nxt;

  // write-one-to-clear helper
  function automatic logic [1:0] w1c(input logic [1:0] cur, input logic [1:0] set,
                                     input logic [1:0] clr);
    w1c = (cur & ~clr) | set;
  endfunction : w1c

  // decoded access phase
  logic acc;
  logic wr;
  logic rd;
  logic monitor_on;
  logic ref_edge;
  logic rst_fire;
  logic flag_rise;
  logic hit;

  assign acc        = psel_i && penable_i && !q_r.ready;
  // writes land at the completing edge, when the master sees ready high
  assign wr         = psel_i && penable_i && pwrite_i && q_r.ready;
  assign rd         = acc && !pwrite_i;
  // RL2 active low power
  assign monitor_on = !q_r.pwr_low;
  assign ref_edge   = pins_s[2] && !q_r.ref_d;
  assign hit        = paddr_i == uvm_pkg::UVM_OFS_STATUS || paddr_i == uvm_pkg::UVM_OFS_CONFIG
                   || paddr_i == uvm_pkg::UVM_OFS_IRQ_ST || paddr_i == uvm_pkg::UVM_OFS_IRQ_MK;

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb begin
    q_nxt       = q_r;
    q_nxt.ready = 1'b0;
    q_nxt.err   = 1'b0;
    q_nxt.wake  = 1'b0;
    q_nxt.ref_d = pins_s[2];
    rst_fire    = 1'b0;
    flag_rise   = 1'b0;

    // reset filter; wait mode does not gate it
    // RL12 runs in wait
    case (q_r.st)
      uvm_pkg::UVM_ST_IDLE: begin
        // RL14 restart on release
        if (!monitor_on || !cmp.below_fall) begin
          q_nxt.rst_cnt = '0;
        // RL3 nine cycle filter
        end else if (q_r.rst_cnt >= RST_LAST) begin
          q_nxt.rst_cnt = '0;
          // RL4 active low enable
          if (!q_r.rst_low) begin
            q_nxt.st  = uvm_pkg::UVM_ST_HOLD;
            rst_fire  = 1'b1;
            // RL13 wake from wait
            q_nxt.wake = wait_mode_i;
          end
        end else begin
          q_nxt.rst_cnt = q_r.rst_cnt + 8'h01;
        end
      end
      uvm_pkg::UVM_ST_HOLD: begin
        // RL5 one cycle release
        if (cmp.above_rise) begin
          q_nxt.st = uvm_pkg::UVM_ST_IDLE;
        end
      end
      default: begin
        q_nxt.st = uvm_pkg::UVM_ST_IDLE;
      end
    endcase

    // RL7 flag from comparator
    if (!monitor_on) begin
      q_nxt.flag_cnt = '0;
    // RL9 clear above rise
    end else if (cmp.above_rise) begin
      q_nxt.flag     = 1'b0;
      q_nxt.flag_cnt = '0;
    // RL14 restart flag count
    end else if (!cmp.below_fall) begin
      q_nxt.flag_cnt = '0;
    // RL8 reference cycle filter
    end else if (ref_edge) begin
      if (q_r.flag_cnt >= FLAG_LAST) begin
        flag_rise  = !q_r.flag;
        q_nxt.flag = 1'b1;
      end else begin
        q_nxt.flag_cnt = q_r.flag_cnt + 8'h01;
      end
    end

    // register writes; RL10 status read-only
    if (wr && paddr_i == uvm_pkg::UVM_OFS_CONFIG) begin
      q_nxt.pwr_low = pwdata_i[uvm_pkg::UVM_BIT_PWR_LOW];
      q_nxt.rst_low = pwdata_i[uvm_pkg::UVM_BIT_RST_LOW];
    end
    if (wr && paddr_i == uvm_pkg::UVM_OFS_IRQ_MK) begin
      q_nxt.mask = pwdata_i[1:0];
    end
    // event bits: set beats clear
    q_nxt.ev = w1c(q_r.ev, {flag_rise, rst_fire},
                   (wr && paddr_i == uvm_pkg::UVM_OFS_IRQ_ST) ? pwdata_i[1:0] : 2'h0);

    // read data
    if (acc) begin
      q_nxt.ready = 1'b1;
      q_nxt.err   = !hit;
      q_nxt.rdata = '0;
      if (rd) begin
        case (paddr_i)
          uvm_pkg::UVM_OFS_STATUS: q_nxt.rdata[uvm_pkg::UVM_BIT_FLAG] = q_r.flag;
          uvm_pkg::UVM_OFS_CONFIG: q_nxt.rdata[1:0] = {q_r.rst_low, q_r.pwr_low};
          uvm_pkg::UVM_OFS_IRQ_ST: q_nxt.rdata[1:0] = q_r.ev;
          uvm_pkg::UVM_OFS_IRQ_MK: q_nxt.rdata[1:0] = q_r.mask;
          default:                 q_nxt.rdata = '0;
        endcase
      end
    end

    // RL6 external pin low
    q_nxt.sys_rst = q_nxt.st == uvm_pkg::UVM_ST_HOLD;
    q_nxt.ext_n   = q_nxt.st != uvm_pkg::UVM_ST_HOLD;
    // RL12 comparator stays powered in wait
    q_nxt.cmp_on  = !q_nxt.pwr_low;
    // RL11 only the wrapper summary, not the monitor
    q_nxt.irq     = |(q_nxt.ev & q_nxt.mask);
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  // RL1 enabled out of reset
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q_r         <= '0;
      q_r.st      <= uvm_pkg::UVM_ST_IDLE;
      q_r.pwr_low <= uvm_pkg::UVM_CONFIG_RST[uvm_pkg::UVM_BIT_PWR_LOW];
      q_r.rst_low <= uvm_pkg::UVM_CONFIG_RST[uvm_pkg::UVM_BIT_RST_LOW];
      q_r.mask    <= uvm_pkg::UVM_MASK_RST;
      q_r.ext_n   <= 1'b1;
      q_r.cmp_on  <= 1'b1;
    end else begin
      q_r <= q_nxt;
    end
  end

  // outputs straight from flops
  assign prdata_o        = q_r.rdata;
  assign pready_o        = q_r.ready;
  assign pslverr_o       = q_r.err;
  assign sys_reset_o     = q_r.sys_rst;
  assign ext_reset_n_o   = q_r.ext_n;
  assign wake_o          = q_r.wake;
  assign comparator_on_o = q_r.cmp_on;
  assign irq_o           = q_r.irq;

endmodule : uvm_monitor
`default_nettype wire

/* File: rtl/uvm_pkg_lv.sv */
// constants, types and register map of the undervoltage monitor
//
// Overview of operation
// RL1 - monitor is active straight out of any reset, no software enable needed
// RL2 - monitoring runs only while the power configuration bit is zero
// RL3 - system reset after nine consecutive cpu cycles at or below falling trip, if enabled
// RL4 - reset-enable bit is active low; one suppresses resets for polling
// RL5 - held reset releases after a single cpu cycle above rising trip level
// RL6 - external active-low reset pin driven low during undervoltage reset
// RL7 - status flag comes from comparator outputs, not the reset machine
// RL8 - flag clear below 32 reference cycles low, set beyond 40 cycles
// RL9 - flag cleared above rising trip, held between the two trip levels
// RL10 - flag is read-only, writes ignored, cleared by any reset
// RL11 - monitor itself never raises an interrupt request
// RL12 - monitor keeps running in wait state while power bit is zero
// RL13 - filtered reset may occur in wait mode and ends wait
// RL14 - both filter counts restart from zero when the low report drops
package uvm_pkg;

  // register byte offsets
  localparam logic [11:0] UVM_OFS_STATUS = 12'h000;
  localparam logic [11:0] UVM_OFS_CONFIG = 12'h004;
  localparam logic [11:0] UVM_OFS_IRQ_ST = 12'h008;
  localparam logic [11:0] UVM_OFS_IRQ_MK = 12'h00C;

  // field positions
  localparam int UVM_BIT_FLAG     = 7;
  localparam int UVM_BIT_PWR_LOW  = 0;
  localparam int UVM_BIT_RST_LOW  = 1;
  localparam int UVM_BIT_EV_RESET = 0;
  localparam int UVM_BIT_EV_FLAG  = 1;

  // reset values
  localparam logic [1:0] UVM_CONFIG_RST = 2'h0;
  localparam logic [1:0] UVM_MASK_RST   = 2'h0;

  // filter lengths
  localparam int UVM_RST_FILTER_CYC  = 9;
  localparam int UVM_FLAG_FILTER_CYC = 36;
  localparam int UVM_FLAG_MIN_CYC    = 32;
  localparam int UVM_FLAG_MAX_CYC    = 40;

  // reset machine states, idle and hold
  typedef enum logic [1:0] {
    UVM_ST_IDLE = 2'h0,
    UVM_ST_HOLD = 2'h1
  } uvm_state_t;

  // comparator decisions
  typedef struct packed {
    logic below_fall;
    logic above_rise;
  } uvm_cmp_t;

endpackage : uvm_pkg

/* File: rtl/uvm_sync.sv */
// two-flop synchroniser for the comparator and reference clock pins
`timescale 1ns/10ps
`default_nettype none
module uvm_sync #(
  parameter int WIDTH = 3
) (
  input  wire logic             clk_sys_i, // system clock
  input  wire logic             rst_n_i,   // async reset, active low
  input  wire logic [WIDTH-1:0] async_i,   // raw inputs
  output logic      [WIDTH-1:0] sync_o     // synchronised inputs
);

  logic [WIDTH-1:0] meta_r;

  // first stage is read only by the second
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_r <= '0;
      sync_o <= '0;
    end else begin
      meta_r <= async_i;
      sync_o <= meta_r;
    end
  end

endmodule : uvm_sync
`default_nettype wire
